// ---- verilog/sfis_top.sv ----
// Multi-line serial flash slave interface state tracker
// Assumes link pins arrive asynchronously and user data on the core clock
`timescale 1ns/1ns

module sfis_top
    import sfis_pkg::*;
#(
    parameter int PU = CYC_PU,
    parameter int RP = CYC_RP,
    parameter int RPH = CYC_RPH,
    parameter int RH = CYC_RH
) (
    input wire logic i_core_clk, // Core clock, 10 MHz
    input wire logic i_rst, // Async reset, high
    input wire logic i_ce, // Clock enable
    input wire logic i_sck, // Link clock pin
    input wire logic i_cs_n, // Chip select pin
    input wire logic [3:0] i_io_in, // IO3..IO0 pin levels
    input wire logic i_reset_n, // Reset pin
    input wire logic i_supply_ok, // Supply above minimum
    input wire logic i_supply_low, // Supply below cutoff
    input wire logic i_quad_enable, // Quad mode bit
    input wire logic [1:0] i_latency_code, // Latency code field
    input wire logic [7:0] i_rd_data, // Next read byte
    output logic [3:0] o_io_out, // IO3..IO0 drive value
    output logic [3:0] o_io_oe, // IO3..IO0 drive enable
    output logic o_ready, // Interface running
    output logic [3:0] o_state, // Interface state
    output logic [7:0] o_opcode, // Captured opcode
    output logic o_opcode_valid, // Opcode held
    output logic [7:0] o_rx_data, // Received byte
    output logic o_rx_strobe, // Received byte pulse
    output logic o_rd_req, // Read byte taken pulse
    output logic o_wp_n_latched, // Write-protect at reg write
    output logic o_cmd_reject // Command refused pulse
);

    // ------------------------------------------------------------
    // Pin synchronisation and reset sequencing
    // ------------------------------------------------------------
    sfis_pin_if #(.N(N_PINS)) pins();

    wire logic [N_PINS-1:0] pin_raw;
    wire logic ready;

    assign pin_raw = {i_supply_low, i_supply_ok, i_reset_n, i_io_in,
        i_cs_n, i_sck};

    sfis_sync #(
        .N(N_PINS),
        .RST_VAL(PIN_RST_VAL)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_async(pin_raw),
        .pins(pins)
    );

    sfis_reset #(
        .PU(PU),
        .RP(RP),
        .RPH(RPH),
        .RH(RH)
    ) u_reset (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_supply_ok(pins.level[PIN_SOK]),
        .i_reset_n(pins.level[PIN_RSTN]),
        .o_ready(ready)
    );

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    sfis_state_t state;
    sfis_state_t next_state;
    sfis_cmd_t cmd;
    logic [5:0] bit_cnt;
    logic [7:0] sh;
    logic [2:0] lat_cnt;
    logic [7:0] out_sh;
    logic [3:0] out_rem;
    logic drv_go;

    // ------------------------------------------------------------
    // Pin views
    // ------------------------------------------------------------
    wire logic cs_n;
    wire logic cs_fall;
    wire logic cs_rise;
    wire logic [3:0] io;
    wire logic wp_n;
    wire logic pause_n;
    wire logic supply_low;
    wire logic selected;
    wire logic pause_act;
    wire logic sck_rise;
    wire logic sck_fall;

    assign cs_n = pins.level[PIN_CS];
    assign cs_fall = pins.fall[PIN_CS];
    assign cs_rise = pins.rise[PIN_CS];
    assign io = pins.level[PIN_IO3:PIN_IO0];
    assign wp_n = pins.level[PIN_IO2];
    assign pause_n = pins.level[PIN_IO3];
    assign supply_low = pins.level[PIN_SLOW];
    assign selected = state != ST_OFF && state != ST_STANDBY;

    // Shared pin is pause only outside quad mode and DDR
    assign pause_act = !i_quad_enable && !cmd.ddr &&
        !cs_n && !pause_n && selected;
    // Paused clock edges are dropped so state holds
    assign sck_rise = pins.rise[PIN_SCK] && !pause_act;
    assign sck_fall = pins.fall[PIN_SCK] && !pause_act;

    // ------------------------------------------------------------
    // Input phase decode
    // ------------------------------------------------------------
    wire logic in_phase;
    wire logic addr_phase;
    wire logic [2:0] ph_w;
    wire logic [5:0] ph_len;
    wire logic ddr_fall_ok;
    wire logic in_edge;
    wire logic shift_en;
    wire logic [7:0] sh_next;
    wire logic [5:0] bit_cnt_inc;
    wire logic phase_done;
    wire logic byte_done;

    assign addr_phase = state == ST_ADDR || state == ST_MODE;
    assign in_phase = addr_phase || state == ST_WDATA;
    assign ph_w = (state == ST_INSTR) ? W1 :
        addr_phase ? cmd.addr_w : cmd.data_w;
    assign ph_len = (state == ST_INSTR) ? OP_BITS :
        (state == ST_ADDR) ? ADDR_BITS : MODE_BITS;

    // DDR address starts on the rising edge after the opcode
    assign ddr_fall_ok = !(state == ST_ADDR && bit_cnt == '0);
    assign in_edge = sck_rise ||
        (cmd.ddr && sck_fall && ddr_fall_ok);
    assign shift_en = (state == ST_INSTR && sck_rise) ||
        (in_phase && in_edge);

    // Lowest line carries the least significant bit of a group
    assign sh_next = (ph_w == W4) ? {sh[3:0], io} :
        (ph_w == W2) ? {sh[5:0], io[1:0]} :
        {sh[6:0], io[0]};
    assign bit_cnt_inc = 6'(bit_cnt + {3'h0, ph_w});
    assign phase_done = bit_cnt_inc == ph_len;
    assign byte_done = bit_cnt_inc[2:0] == 3'h0;

    // ------------------------------------------------------------
    // Command selection
    // ------------------------------------------------------------
    sfis_cmd_t dec;
    wire logic quad_ok;
    wire logic [2:0] lat_cyc;
    wire logic [2:0] lat_last;
    sfis_state_t instr_next;
    sfis_state_t post_mode;
    sfis_state_t post_addr;

    assign dec = cmd_decode(sh_next);
    assign quad_ok = i_quad_enable ||
        (dec.addr_w != W4 && dec.data_w != W4);
    assign lat_cyc = {i_latency_code, 1'b0};
    assign lat_last = 3'(lat_cyc - 3'h1);

    assign instr_next = (!dec.known || !quad_ok) ? ST_IGNORE :
        dec.has_addr ? ST_ADDR :
        dec.wr ? ST_WDATA : ST_IGNORE;
    assign post_mode = (cmd.lat && lat_cyc != 3'h0) ? ST_LAT :
        cmd.rd ? ST_OUT :
        cmd.wr ? ST_WDATA : ST_IGNORE;
    assign post_addr = cmd.mode ? ST_MODE : post_mode;

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (ready) next_state = ST_STANDBY;
            end
            ST_STANDBY: begin
                if (cs_fall) begin
                    next_state = supply_low ? ST_IGNORE : ST_INSTR;
                end
            end
            ST_INSTR: begin
                if (shift_en && phase_done) next_state = instr_next;
            end
            ST_ADDR: begin
                if (shift_en && phase_done) next_state = post_addr;
            end
            ST_MODE: begin
                if (shift_en && phase_done) next_state = post_mode;
            end
            ST_LAT: begin
                if (sck_rise && lat_cnt == lat_last) next_state = ST_OUT;
            end
            ST_OUT, ST_WDATA, ST_IGNORE: next_state = state;
            default: next_state = ST_STANDBY;
        endcase
        if (cs_rise && state != ST_OFF) next_state = ST_STANDBY;
        if (!ready) next_state = ST_OFF;
    end

    // ------------------------------------------------------------
    // Output phase decode
    // ------------------------------------------------------------
    wire logic drive_edge;
    wire logic [7:0] out_src;
    wire logic [3:0] out_rem_next;
    wire logic [3:0] out_bits;
    wire logic [3:0] out_mask;
    wire logic [3:0] next_oe;

    // First data leaves on a falling edge, DDR then uses both
    assign drive_edge = state == ST_OUT &&
        (sck_fall || (cmd.ddr && sck_rise && drv_go));
    assign out_src = (out_rem == 4'h0) ? i_rd_data : out_sh;
    assign out_rem_next = 4'(((out_rem == 4'h0) ? OUT_BYTE : out_rem) -
        {1'b0, cmd.data_w});
    assign out_bits = (cmd.data_w == W4) ? out_src[7:4] :
        (cmd.data_w == W2) ? {2'h0, out_src[7:6]} :
        {2'h0, out_src[7], 1'b0};
    assign out_mask = (cmd.data_w == W4) ? 4'hf :
        (cmd.data_w == W2) ? 4'h3 : 4'h2;
    // Lines float outside output cycles and during a pause
    assign next_oe = (next_state == ST_OUT && (drv_go || drive_edge) &&
        !pause_act) ? out_mask : 4'h0;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_OFF;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_cnt <= '0;
            sh <= '0;
        end else if (i_ce) begin
            if (next_state != state) begin
                bit_cnt <= '0;
            end else if (shift_en) begin
                bit_cnt <= bit_cnt_inc;
            end
            if (shift_en) sh <= sh_next;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cmd <= '0;
            o_opcode <= '0;
            o_opcode_valid <= 1'b0;
        end else if (i_ce) begin
            if (next_state == ST_STANDBY || next_state == ST_OFF) begin
                cmd <= '0;
                o_opcode_valid <= 1'b0;
            end else if (state == ST_INSTR && shift_en && phase_done) begin
                cmd <= dec;
                o_opcode <= sh_next;
                o_opcode_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wp_n_latched <= 1'b1;
        end else if (i_ce) begin
            if (state == ST_INSTR && shift_en && phase_done &&
                sh_next == OP_WR_REGS) begin
                o_wp_n_latched <= wp_n;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_data <= '0;
            o_rx_strobe <= 1'b0;
            o_cmd_reject <= 1'b0;
        end else if (i_ce) begin
            o_rx_strobe <= in_phase && shift_en && byte_done;
            if (in_phase && shift_en && byte_done) o_rx_data <= sh_next;
            o_cmd_reject <= state == ST_STANDBY && cs_fall &&
                supply_low;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            lat_cnt <= '0;
        end else if (i_ce) begin
            if (state != ST_LAT) begin
                lat_cnt <= '0;
            end else if (sck_rise) begin
                lat_cnt <= 3'(lat_cnt + 3'h1);
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            out_sh <= '0;
            out_rem <= '0;
            drv_go <= 1'b0;
            o_rd_req <= 1'b0;
        end else if (i_ce) begin
            o_rd_req <= drive_edge && out_rem == 4'h0;
            if (state != ST_OUT) begin
                out_rem <= '0;
                drv_go <= 1'b0;
            end else if (drive_edge) begin
                out_sh <= 8'(out_src << cmd.data_w);
                out_rem <= out_rem_next;
                drv_go <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_io_out <= '0;
            o_io_oe <= '0;
        end else if (i_ce) begin
            if (drive_edge) o_io_out <= out_bits;
            o_io_oe <= next_oe;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ready <= 1'b0;
            o_state <= '0;
        end else if (i_ce) begin
            o_ready <= ready;
            o_state <= next_state;
        end
    end

endmodule // sfis_top

// ---- verilog/sfis_pkg.sv ----
// Constants, types and command decode for the flash interface tracker
// Assumes a core clock much faster than the link clock

package sfis_pkg;

    // ------------------------------------------------------------
    // Clock and pin layout
    // ------------------------------------------------------------
    localparam int CORE_CLK_MHZ = 10;
    localparam int N_PINS = 9;
    localparam int PIN_SCK = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_IO0 = 2;
    localparam int PIN_IO2 = 4;
    localparam int PIN_IO3 = 5;
    localparam int PIN_RSTN = 6;
    localparam int PIN_SOK = 7;
    localparam int PIN_SLOW = 8;
    localparam logic [8:0] PIN_RST_VAL = 9'h07e;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int T_PU_US = 100;
    localparam int T_RP_NS = 200;
    localparam int RESET_RECOVERY_TIME_US = 35;
    localparam int T_RH_NS = 50;
    localparam int CYC_PU = T_PU_US * CORE_CLK_MHZ;
    localparam int CYC_RP = (T_RP_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int CYC_RPH = RESET_RECOVERY_TIME_US * CORE_CLK_MHZ;
    localparam int CYC_RH = (T_RH_NS * CORE_CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // Command framing
    // ------------------------------------------------------------
    localparam logic [5:0] OP_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [5:0] MODE_BITS = 6'h08;
    localparam logic [2:0] W1 = 3'h1;
    localparam logic [2:0] W2 = 3'h2;
    localparam logic [2:0] W4 = 3'h4;
    localparam logic [3:0] OUT_BYTE = 4'h8;

    localparam logic [7:0] OP_READ = 8'h01;
    localparam logic [7:0] OP_FAST = 8'h02;
    localparam logic [7:0] OP_DUAL_OUT = 8'h03;
    localparam logic [7:0] OP_QUAD_OUT_RD = 8'h04;
    localparam logic [7:0] OP_DUAL_IO = 8'h05;
    localparam logic [7:0] OP_QUAD_IO = 8'h06;
    localparam logic [7:0] OP_DDR_FAST = 8'h07;
    localparam logic [7:0] OP_DDR_DUAL = 8'h08;
    localparam logic [7:0] OP_DDR_QUAD = 8'h09;
    localparam logic [7:0] OP_PROG = 8'h0a;
    localparam logic [7:0] OP_QUAD_PROG = 8'h0b;
    localparam logic [7:0] OP_WR_REGS = 8'h0c;

    typedef enum logic [3:0] {
        ST_OFF, ST_STANDBY, ST_INSTR, ST_ADDR, ST_MODE,
        ST_LAT, ST_OUT, ST_WDATA, ST_IGNORE
    } sfis_state_t;

    typedef enum logic [1:0] {
        RS_OFF, RS_PUP, RS_RUN, RS_HWRST
    } sfis_rst_state_t;

    typedef struct packed {
        logic known;
        logic has_addr;
        logic [2:0] addr_w;
        logic mode;
        logic lat;
        logic rd;
        logic wr;
        logic [2:0] data_w;
        logic ddr;
    } sfis_cmd_t;

    // Opcode to transfer format
    function automatic sfis_cmd_t cmd_decode(input logic [7:0] op);
        sfis_cmd_t c;
        c = '0;
        c.known = 1'b1;
        c.has_addr = 1'b1;
        c.addr_w = W1;
        c.data_w = W1;
        case (op)
            OP_READ: c.rd = 1'b1;
            OP_FAST: {c.lat, c.rd} = 2'h3;
            OP_DUAL_OUT: {c.lat, c.rd, c.data_w} = {2'h3, W2};
            OP_QUAD_OUT_RD: {c.lat, c.rd, c.data_w} = {2'h3, W4};
            OP_DUAL_IO: {c.mode, c.lat, c.rd, c.addr_w, c.data_w} =
                {3'h7, W2, W2};
            OP_QUAD_IO: {c.mode, c.lat, c.rd, c.addr_w, c.data_w} =
                {3'h7, W4, W4};
            OP_DDR_FAST: {c.mode, c.lat, c.rd, c.ddr} = 4'hf;
            OP_DDR_DUAL: {c.mode, c.lat, c.rd, c.ddr, c.addr_w, c.data_w} =
                {4'hf, W2, W2};
            OP_DDR_QUAD: {c.mode, c.lat, c.rd, c.ddr, c.addr_w, c.data_w} =
                {4'hf, W4, W4};
            OP_PROG: c.wr = 1'b1;
            OP_QUAD_PROG: {c.wr, c.data_w} = {1'b1, W4};
            OP_WR_REGS: {c.has_addr, c.wr} = 2'h1;
            default: {c.known, c.has_addr} = 2'h0;
        endcase
        return c;
    endfunction

endpackage

// ---- verilog/sfis_pin_if.sv ----
// Interface carrying synchronised pin levels and their edges
// Assumes one driver module and one receiving module
`timescale 1ns/1ns

interface sfis_pin_if #(parameter int N = 9);
    logic [N-1:0] level;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    modport drv(output level, output rise, output fall);
    modport rcv(input level, input rise, input fall);
endinterface

// ---- verilog/sfis_sync.sv ----
// Two-stage synchroniser with edge detection for all link pins
// Assumes asynchronous inputs and a free-running core clock
`timescale 1ns/1ns

module sfis_sync #(
    parameter int N = 9,
    parameter logic [N-1:0] RST_VAL = '0
) (
    input wire logic i_core_clk, // Core clock
    input wire logic i_rst, // Async reset, high
    input wire logic i_ce, // Clock enable
    input wire logic [N-1:0] i_async, // Raw pin levels
    sfis_pin_if.drv pins // Synced levels and edges
);

    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            meta <= RST_VAL;
            sync <= RST_VAL;
            prev <= RST_VAL;
        end else if (i_ce) begin
            meta <= i_async;
            sync <= meta;
            prev <= sync;
        end
    end

    assign pins.level = sync;
    assign pins.rise = sync & ~prev;
    assign pins.fall = ~sync & prev;

endmodule // sfis_sync

// ---- verilog/sfis_reset.sv ----
// Power-up and pin reset sequencing
// Assumes synchronised supply and reset pin levels
`timescale 1ns/1ns

module sfis_reset
    import sfis_pkg::*;
#(
    parameter int PU = CYC_PU,
    parameter int RP = CYC_RP,
    parameter int RPH = CYC_RPH,
    parameter int RH = CYC_RH
) (
    input wire logic i_core_clk, // Core clock
    input wire logic i_rst, // Async reset, high
    input wire logic i_ce, // Clock enable
    input wire logic i_supply_ok, // Supply above minimum
    input wire logic i_reset_n, // Reset pin level
    output logic o_ready // Interface may run
);

    localparam logic [15:0] PU_END = 16'(PU - 1);
    localparam logic [15:0] RP_END = 16'(RP - 1);
    localparam logic [15:0] RPH_END = 16'(RPH);
    localparam logic [15:0] RH_END = 16'(RH);

    sfis_rst_state_t rs;
    sfis_rst_state_t next_rs;
    logic [15:0] cnt;
    logic [15:0] hcnt;
    logic [15:0] next_cnt;
    logic [15:0] next_hcnt;

    assign next_cnt = (rs != next_rs || rs == RS_OFF) ? '0 :
        (rs == RS_RUN && i_reset_n) ? '0 :
        (rs == RS_HWRST && cnt == RPH_END) ? cnt : 16'(cnt + 16'h0001);
    assign next_hcnt = !i_reset_n ? '0 :
        (hcnt == RH_END) ? hcnt : 16'(hcnt + 16'h0001);

    always_comb begin
        next_rs = rs;
        case (rs)
            RS_OFF: next_rs = RS_PUP;
            RS_PUP: if (cnt == PU_END) next_rs = RS_RUN;
            RS_RUN: if (!i_reset_n && cnt == RP_END) next_rs = RS_HWRST;
            RS_HWRST: begin
                if (cnt == RPH_END && hcnt == RH_END) next_rs = RS_RUN;
            end
            default: next_rs = RS_OFF;
        endcase
        if (!i_supply_ok) next_rs = RS_OFF;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rs <= RS_OFF;
            cnt <= '0;
            hcnt <= '0;
            o_ready <= 1'b0;
        end else if (i_ce) begin
            rs <= next_rs;
            cnt <= next_cnt;
            hcnt <= next_hcnt;
            o_ready <= (next_rs == RS_RUN);
        end
    end

endmodule // sfis_reset

// ---- verif/sfis_assertions.sv ----
// Port checker for the flash interface tracker
// Assumes a bind to sfis_top, ports matched by name
`timescale 1ns/1ns
module sfis_assertions
    import sfis_pkg::*;
(
    input wire logic i_core_clk, // Clock
    input wire logic i_rst, // Reset
    input wire logic i_cs_n, // Select
    input wire logic [3:0] i_io_in, // Pins
    input wire logic i_supply_low, // Low supply
    input wire logic i_quad_enable, // Quad mode
    input wire logic [3:0] o_io_oe, // Drive enable
    input wire logic o_ready, // Running
    input wire logic [3:0] o_state, // State
    input wire logic [7:0] o_opcode, // Opcode
    input wire logic o_opcode_valid, // Opcode held
    input wire logic o_rd_req, // Byte taken
    input wire logic o_wp_n_latched, // Protect level
    input wire logic o_cmd_reject // Refused
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    // Pause in a plain read output
    wire logic pz = !i_io_in[3] && !i_quad_enable && !i_cs_n &&
        o_state == ST_OUT && o_opcode < OP_DDR_FAST;
    a_select_start: assert property ($fell(i_cs_n) && !i_supply_low
        && o_state == ST_STANDBY |-> ##[2:5] o_state == ST_INSTR)
        else $error("no capture");
    a_select_end: assert property ($rose(i_cs_n) |-> ##[1:6]
        (o_state inside {ST_STANDBY, ST_OFF} && !o_opcode_valid))
        else $error("no standby");
    a_off_quiet: assert property (!o_ready[*2] |-> o_io_oe == 4'h0)
        else $error("drive while off");
    a_input_quiet: assert property (o_state inside {ST_INSTR, ST_ADDR,
        ST_MODE, ST_LAT, ST_WDATA} |-> !o_io_oe[1]) else $error("so driven");
    a_pause_float: assert property (pz[*6] |=> o_io_oe == 4'h0)
        else $error("drive in pause");
    a_pause_freeze: assert property (pz[*6] |=> $stable(o_state)
        && !o_rd_req) else $error("moved in pause");
    a_reject_ignore: assert property (o_cmd_reject |=> !o_cmd_reject
        ##[0:3] o_state == ST_IGNORE) else $error("reject");
    a_wp_owner: assert property ($changed(o_wp_n_latched)
        |-> o_opcode == OP_WR_REGS) else $error("protect taken");
    cover property (o_state == ST_OUT);
    cover property (pz);
    cover property (o_cmd_reject);
endmodule // sfis_assertions

// ---- verif/sfis_h.sv ----
// Host controller model: select, link clock and data
// Assumes the bench resolves pins against device drive
`timescale 1ns/1ns
module sfis_h (
    input wire logic i_clk, // Core clock
    output logic o_sck, // Link clock
    output logic o_cs_n, // Select
    output logic [3:0] o_io // IO3..IO0
);
    initial begin
        o_sck = 1'h0;
        o_cs_n = 1'h1;
        o_io = 4'hc;
    end
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_clk);
            if (o_cs_n) o_io <= ~o_io; // Released lines wander
        end
    endtask
    task automatic sel(input logic b);
        o_cs_n <= b;
        o_io <= 4'hc;
        tick(8);
    endtask
    task automatic bit1(input logic [3:0] v);
        o_io <= v;
        tick(4);
        o_sck <= 1'h1;
        tick(4);
        o_sck <= 1'h0;
    endtask
    task automatic send(input logic [7:0] b, input logic [2:0] hi);
        for (int i = 7; i >= 0; i--) bit1({hi, b[i]});
    endtask
endmodule // sfis_h

// ---- verif/serial_flash_interface_states_tb.sv ----
// Bench for the flash interface tracker
// Assumes package, design, host model and checker compiled first
`timescale 1ns/1ns
module serial_flash_interface_states_tb;
    import sfis_pkg::*;
    logic clk, rst, rstn, slow, sck, csn, opv, rdy, wpl, rej, req;
    logic ce, sok, qe, rxs;
    logic [1:0] lat;
    logic [3:0] hio, out, oe, st;
    logic [7:0] rd, opc, rxd;
    int err_count = 0;
    int num_checks = 0;
    int rejs = 0;
    int rxn = 0;
    wire logic [3:0] pin = (oe & out) | (~oe & hio);
    sfis_h sfis_h_inst(.i_clk(clk), .o_sck(sck), .o_cs_n(csn), .o_io(hio));
    sfis_top #(.PU(20), .RPH(10)) sfis_top_inst(.i_core_clk(clk),
        .i_rst(rst), .i_ce(ce), .i_sck(sck), .i_cs_n(csn), .i_io_in(pin),
        .i_reset_n(rstn), .i_supply_ok(sok), .i_supply_low(slow),
        .i_quad_enable(qe), .i_latency_code(lat), .i_rd_data(rd),
        .o_io_out(out), .o_io_oe(oe), .o_ready(rdy), .o_state(st),
        .o_opcode(opc), .o_opcode_valid(opv), .o_rx_data(rxd),
        .o_rx_strobe(rxs), .o_rd_req(req), .o_wp_n_latched(wpl),
        .o_cmd_reject(rej));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (req === 1'h1) rd <= rd + 8'h11;
        if (rej === 1'h1) rejs <= rejs + 1;
        if (rxs === 1'h1) rxn <= rxn + 1;
    end
    task automatic check(input string n, input logic [31:0] s, e);
        #1;
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run;
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_ready;
        for (int i = 0; i < 80 && st !== ST_STANDBY; i++) @(posedge clk);
    endtask
    task automatic t_wr;
        sfis_h_inst.sel(1'h0);
        sfis_h_inst.send(OP_WR_REGS, 3'h4);
        check("opcode", opc, OP_WR_REGS);
        check("wp", wpl, 1'h0);
        sfis_h_inst.sel(1'h1);
        check("st_end", st, ST_STANDBY);
    endtask
    task automatic t_read;
        logic [15:0] e = 16'ha5b6;
        sfis_h_inst.sel(1'h0);
        sfis_h_inst.send(OP_READ, 3'h6);
        for (int i = 0; i < 3; i++) sfis_h_inst.send(8'h3c, 3'h6);
        check("oe_addr", oe, 4'h0);
        check("rx_cnt", rxn, 3);
        check("rx_byte", rxd, 8'h3c);
        for (int i = 15; i >= 0; i--) fork
            sfis_h_inst.bit1(4'hc);
            begin
                repeat (4) @(posedge clk);
                check("so", out[1], e[i]);
            end
        join
        check("oe_out", oe, 4'h2);
        sfis_h_inst.bit1(4'h4);
        sfis_h_inst.bit1(4'h4);
        check("oe_hold", oe, 4'h0);
        check("st_hold", st, ST_OUT);
        sfis_h_inst.bit1(4'hc);
        repeat (4) @(posedge clk);
        check("oe_back", oe, 4'h2);
        sfis_h_inst.sel(1'h1);
        check("valid", opv, 1'h0);
        check("wp_kept", wpl, 1'h0);
    endtask
    task automatic t_quad;
        qe <= 1'h1;
        lat <= 2'h1;
        rd <= 8'h9e;
        sfis_h_inst.sel(1'h0);
        sfis_h_inst.send(OP_QUAD_OUT_RD, 3'h0);
        for (int i = 0; i < 3; i++) sfis_h_inst.send(8'h00, 3'h0);
        sfis_h_inst.bit1(4'h0);
        check("st_lat", st, ST_LAT);
        sfis_h_inst.bit1(4'h0);
        repeat (4) @(posedge clk);
        check("qd_hi", out, 4'h9);
        check("oe_quad", oe, 4'hf);
        sfis_h_inst.bit1(4'h0);
        repeat (4) @(posedge clk);
        check("qd_lo", out, 4'he);
        sfis_h_inst.sel(1'h1);
        qe <= 1'h0;
        lat <= 2'h0;
    endtask
    task automatic t_rej;
        slow <= 1'h1;
        repeat (4) @(posedge clk);
        sfis_h_inst.sel(1'h0);
        check("st_rej", st, ST_IGNORE);
        check("rej", rejs, 1);
        sfis_h_inst.sel(1'h1);
        slow <= 1'h0;
    endtask
    task automatic t_rst;
        rstn <= 1'h0;
        repeat (8) @(posedge clk);
        check("rdy_rst", rdy, 1'h0);
        rstn <= 1'h1;
        wait_ready;
        check("st_rst", st, ST_STANDBY);
        sfis_h_inst.bit1(4'h0);
        check("st_idle", st, ST_STANDBY);
        sok <= 1'h0;
        repeat (6) @(posedge clk);
        check("rdy_off", rdy, 1'h0);
        sok <= 1'h1;
        wait_ready;
        check("st_pwr", st, ST_STANDBY);
    endtask
    initial begin
        rst = 1'h1;
        rstn = 1'h1;
        ce = 1'h1;
        sok = 1'h1;
        qe = 1'h0;
        lat = 2'h0;
        slow = 1'h0;
        rd = 8'ha5;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        check("st_off", st, ST_OFF);
        wait_ready;
        check("st_up", st, ST_STANDBY);
        t_wr;
        t_read;
        t_quad;
        t_rej;
        t_rst;
        complete_run;
    end
    initial begin
        #400000;
        err_count++;
        complete_run;
    end
endmodule // serial_flash_interface_states_tb
bind sfis_top sfis_assertions sfis_assertions_inst(.*);
